// ### logic/zqc_controller.sv
`default_nettype none

module zqc_controller #(
  parameter int INIT_CYCLES = zqc_pkg::INIT_CYCLES,
  parameter int OPER_CYCLES = zqc_pkg::OPER_CYCLES,
  parameter int SHORT_CYCLES = zqc_pkg::SHORT_CYCLES,
  parameter int SR_EXIT_CYCLES = zqc_pkg::SR_EXIT_CYCLES,
  parameter int PRECHARGE_CYCLES = zqc_pkg::PRECHARGE_CYCLES,
  parameter int DRIFT_CYCLES = zqc_pkg::DRIFT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  zqc_if.controller link,
  // user requests, level held until grant
  input wire logic reqLong,
  input wire logic reqShort,
  input wire logic selfRefreshReq,
  input wire logic banksOpen,
  input wire logic userActivity,
  // shared reference resistor arbitration
  input wire logic resistorBusy,
  output logic resistorClaim,
  // status
  output logic grant,
  output logic calWindow
);
  // ==========================================================
  logic [zqc_pkg::CNT_W-1:0] quietCnt;
  logic [zqc_pkg::CNT_W-1:0] srCnt;
  logic [zqc_pkg::CNT_W-1:0] preCnt;
  logic [zqc_pkg::CNT_W-1:0] driftCnt;
  logic firstIssued;
  logic srPrev;
  logic issueLong;
  logic issueShort;
  logic ready;

  // ready only after precharge, exit delay, no other calibration
  // srPrev covers the edge before the exit delay is loaded
  assign ready = quietCnt == '0 && srCnt == '0 && preCnt == '0
    && !srPrev && !banksOpen && !selfRefreshReq && !resistorBusy;
  // first long is forced before anything else
  assign issueLong = ready && (reqLong || !firstIssued);
  assign issueShort = ready && firstIssued && !reqLong && reqShort
    && driftCnt == '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quietCnt <= '0;
      firstIssued <= 1'b0;
    end else if (issueLong) begin
      quietCnt <= zqc_pkg::CNT_W'(firstIssued ? OPER_CYCLES : INIT_CYCLES);
      firstIssued <= 1'b1;
    end else if (issueShort) begin
      quietCnt <= zqc_pkg::CNT_W'(SHORT_CYCLES);
    end else if (quietCnt != '0) begin
      quietCnt <= quietCnt - 1'b1;
    end
  end

  // exit delay counted from leaving self refresh; dll lock not waited
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srPrev <= 1'b0;
      srCnt <= '0;
    end else begin
      srPrev <= selfRefreshReq;
      if (srPrev && !selfRefreshReq) begin
        srCnt <= zqc_pkg::CNT_W'(SR_EXIT_CYCLES);
      end else if (srCnt != '0) begin
        srCnt <= srCnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      preCnt <= '0;
    end else if (banksOpen) begin
      preCnt <= zqc_pkg::CNT_W'(PRECHARGE_CYCLES);
    end else if (preCnt != '0) begin
      preCnt <= preCnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      driftCnt <= '0;
    end else if (issueShort) begin
      driftCnt <= zqc_pkg::CNT_W'(DRIFT_CYCLES);
    end else if (driftCnt != '0) begin
      driftCnt <= driftCnt - 1'b1;
    end
  end

  // ==========================================================
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      link.cmd <= zqc_pkg::ZQC_NOP;
      link.cmdValid <= 1'b0;
    end else begin
      link.cmdValid <= issueLong || issueShort;
      link.cmd <= issueLong ? zqc_pkg::ZQC_LONG
        : (issueShort ? zqc_pkg::ZQC_SHORT : zqc_pkg::ZQC_NOP);
    end
  end

  // user traffic blocked through the window
  // device counts from acceptance, one edge later, so its busy ends the window
  assign calWindow = quietCnt != '0 || link.busy;
  assign link.otherActivity = userActivity && !calWindow && !link.cmdValid;
  assign link.allPrecharged = !banksOpen;
  assign link.selfRefresh = selfRefreshReq && !calWindow;
  assign resistorClaim = calWindow || link.cmdValid;
  assign grant = issueLong || issueShort;
endmodule : zqc_controller

`default_nettype wire

// ### logic/zqc_device.sv
`default_nettype none

module zqc_device #(
  parameter int INIT_CYCLES = zqc_pkg::INIT_CYCLES,
  parameter int OPER_CYCLES = zqc_pkg::OPER_CYCLES,
  parameter int SHORT_CYCLES = zqc_pkg::SHORT_CYCLES,
  parameter int CODE_W = zqc_pkg::CODE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  zqc_if.device link,
  // comparator from reference pin, high when leg is too strong
  input wire logic cmpHigh,
  // calibration results and analog controls
  output logic [CODE_W-1:0] pullUpCode,
  output logic [CODE_W-1:0] pullDownCode,
  output logic calCurrentOn,
  output logic calDone
);
  // ==========================================================
  // comparator sync, it is an analog level
  logic cmpMeta;
  logic cmpSync;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmpMeta <= 1'b0;
      cmpSync <= 1'b0;
    end else begin
      cmpMeta <= cmpHigh;
      cmpSync <= cmpMeta;
    end
  end

  // ==========================================================
  // sequencer
  zqc_pkg::zqc_state_t state;
  logic firstDone;
  logic [zqc_pkg::CNT_W-1:0] timer;
  logic [zqc_pkg::CNT_W-1:0] tuneCnt;
  logic [CODE_W-1:0] approxReg;
  logic [CODE_W-1:0] pdTrial;
  logic accept;
  logic [zqc_pkg::CNT_W-1:0] budget;
  logic [zqc_pkg::CNT_W-1:0] halfBudget;

  // self refresh has no path here: only a command starts a run
  assign accept = link.cmdValid && (link.cmd != zqc_pkg::ZQC_NOP)
    && state == zqc_pkg::ZQC_IDLE;

  always_comb begin
    if (link.cmd == zqc_pkg::ZQC_SHORT) begin
      budget = zqc_pkg::CNT_W'(SHORT_CYCLES);
    end else if (!firstDone) begin
      budget = zqc_pkg::CNT_W'(INIT_CYCLES);
    end else begin
      budget = zqc_pkg::CNT_W'(OPER_CYCLES);
    end
  end
  // half of the window for pull-up, the rest less one cycle for pull-down, transfer in the last cycle
  assign halfBudget = budget >> 1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= zqc_pkg::ZQC_IDLE;
      timer <= '0;
      tuneCnt <= '0;
      firstDone <= 1'b0;
    end else begin
      case (state)
        zqc_pkg::ZQC_IDLE: begin
          if (accept) begin
            state <= zqc_pkg::ZQC_PULLUP;
            timer <= budget - 1'b1;
            tuneCnt <= halfBudget - 1'b1;
            if (link.cmd == zqc_pkg::ZQC_LONG) begin
              firstDone <= 1'b1;
            end
          end
        end
        zqc_pkg::ZQC_PULLUP: begin
          timer <= timer - 1'b1;
          tuneCnt <= tuneCnt - 1'b1;
          if (tuneCnt == '0) begin
            state <= zqc_pkg::ZQC_PULLDN;
            tuneCnt <= timer - 2'h2;
          end
        end
        zqc_pkg::ZQC_PULLDN: begin
          timer <= timer - 1'b1;
          tuneCnt <= tuneCnt - 1'b1;
          if (tuneCnt == '0) begin
            state <= zqc_pkg::ZQC_XFER;
          end
        end
        zqc_pkg::ZQC_XFER: begin
          state <= zqc_pkg::ZQC_IDLE;
        end
        default: begin
          state <= zqc_pkg::ZQC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // successive tuning, one step per cycle; a short run of 64 cycles
  // covers far more than the small drift it must correct
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      approxReg <= zqc_pkg::CODE_MID;
      pdTrial <= zqc_pkg::CODE_MID;
    end else if (state == zqc_pkg::ZQC_PULLUP) begin
      if (cmpSync && approxReg != '0) begin
        approxReg <= approxReg - 1'b1;
      end else if (!cmpSync && approxReg != '1) begin
        approxReg <= approxReg + 1'b1;
      end
    end else if (state == zqc_pkg::ZQC_PULLDN) begin
      if (cmpSync && pdTrial != '0) begin
        pdTrial <= pdTrial - 1'b1;
      end else if (!cmpSync && pdTrial != '1) begin
        pdTrial <= pdTrial + 1'b1;
      end
    end
  end

  // ==========================================================
  // codes reach the IO only at transfer, never mid-tune
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pullUpCode <= zqc_pkg::CODE_MID;
      pullDownCode <= zqc_pkg::CODE_MID;
      calDone <= 1'b0;
    end else begin
      calDone <= 1'b0;
      if (state == zqc_pkg::ZQC_XFER) begin
        pullUpCode <= approxReg;
        pullDownCode <= pdTrial;
        calDone <= 1'b1;
      end
    end
  end

  // current only while legs are being compared
  assign calCurrentOn = state == zqc_pkg::ZQC_PULLUP
    || state == zqc_pkg::ZQC_PULLDN;
  assign link.busy = state != zqc_pkg::ZQC_IDLE;
endmodule : zqc_device

`default_nettype wire

// ### logic/zqc_if.sv
`default_nettype none

interface zqc_if;
  // ==========================================================
  // command channel from controller to device
  zqc_pkg::zqc_cmd_t cmd;
  logic cmdValid;
  logic otherActivity;
  logic allPrecharged;
  logic selfRefresh;
  // device status back to controller side
  logic busy;

  modport device (
    input cmd, cmdValid, otherActivity, allPrecharged, selfRefresh,
    output busy
  );
  modport controller (
    output cmd, cmdValid, otherActivity, allPrecharged, selfRefresh,
    input busy
  );
endinterface : zqc_if

`default_nettype wire

// ### logic/zqc_pkg.sv
// Summary of operation
// - long command runs engine, then updates impedances
// - controller issues long command during initialization
// - first long after reset gets initial period
// - later long commands get operating period
// - short command finishes within short period
// - short command corrects error within 64 cycles
// - controller spaces short commands by drift formula
// - channel stays quiet during any calibration period
// - calibration current path off once calibrated
// - all banks precharged before any calibration
// - calibration allowed during lock time after self refresh
// - no self recalibration on self-refresh exit
// - calibration waits self-refresh exit delay
// - shared reference resistor calibrations never overlap (two controllers ready in the same cycle both issue)
// - pull-up tuned before pull-down, both codes stored together at transfer
`default_nettype none

package zqc_pkg;
  // ==========================================================
  // timing, in clock_cycles of the command clock, plus counter width, code width and mid code
  localparam int INIT_CYCLES = 512;
  localparam int OPER_CYCLES = 256;
  localparam int SHORT_CYCLES = 64;
  localparam int SR_EXIT_CYCLES = 8;
  localparam int PRECHARGE_CYCLES = 4;
  localparam int CNT_W = 16;
  localparam int CODE_W = 6;
  localparam int DRIFT_CYCLES = 32;
  localparam logic [CODE_W-1:0] CODE_MID = 6'h20;

  // ==========================================================
  // command encoding on the link
  typedef enum logic [1:0] {
    ZQC_NOP = 2'h0,
    ZQC_LONG = 2'h1,
    ZQC_SHORT = 2'h2
  } zqc_cmd_t;

  // ==========================================================
  // engine phases
  typedef enum logic [2:0] {
    ZQC_IDLE = 3'h0,
    ZQC_PULLUP = 3'h1,
    ZQC_PULLDN = 3'h2,
    ZQC_XFER = 3'h3,
    ZQC_WAIT = 3'h4
  } zqc_state_t;
endpackage : zqc_pkg

`default_nettype wire

// ### test/zqc_asserts.sv
`default_nettype none

module zqc_asserts #(
  parameter int INIT_CYCLES = zqc_pkg::INIT_CYCLES,
  parameter int OPER_CYCLES = zqc_pkg::OPER_CYCLES,
  parameter int SHORT_CYCLES = zqc_pkg::SHORT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link
  input var zqc_pkg::zqc_cmd_t cmd,
  input wire logic cmdValid,
  input wire logic otherActivity,
  input wire logic allPrecharged,
  input wire logic selfRefresh,
  input wire logic busy
);
  // ==========================================================
  // busy length and kind of the running command
  logic [15:0] cnt;
  logic seenLong;
  logic firstLong;
  logic isShort;
  logic take;
  assign take = cmdValid && cmd != zqc_pkg::ZQC_NOP && !busy;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cnt <= '0;
    else cnt <= busy ? cnt + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seenLong <= 1'b0;
      firstLong <= 1'b0;
      isShort <= 1'b0;
    end else if (take) begin
      seenLong <= seenLong | (cmd == zqc_pkg::ZQC_LONG);
      firstLong <= !seenLong && cmd == zqc_pkg::ZQC_LONG;
      isShort <= cmd == zqc_pkg::ZQC_SHORT;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // properties
  property p_take; take |=> busy; endproperty
  a_take: assert property (p_take) else $error("busy missing after command");
  property p_first; cmdValid && !seenLong |-> cmd == zqc_pkg::ZQC_LONG; endproperty
  a_first: assert property (p_first) else $error("first command not long");
  property p_prech; cmdValid |-> allPrecharged; endproperty
  a_prech: assert property (p_prech) else $error("command with open banks");
  property p_quiet; cmdValid |=> (!otherActivity && !cmdValid) [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("channel busy in window");
  property p_busyquiet; busy |-> !otherActivity; endproperty
  a_busyquiet: assert property (p_busyquiet) else $error("traffic while device busy");
  property p_srx; $fell(selfRefresh) |-> !cmdValid [*7]; endproperty
  a_srx: assert property (p_srx) else $error("command too soon after exit");
  property p_init;
    $fell(busy) && firstLong |-> cnt >= INIT_CYCLES - 1 && cnt <= INIT_CYCLES + 2;
  endproperty
  a_init: assert property (p_init) else $error("first long length wrong");
  property p_oper;
    $fell(busy) && !firstLong && !isShort |-> cnt >= OPER_CYCLES - 1 && cnt <= OPER_CYCLES + 2;
  endproperty
  a_oper: assert property (p_oper) else $error("long length wrong");
  property p_short;
    $fell(busy) && isShort |-> cnt >= SHORT_CYCLES - 1 && cnt <= SHORT_CYCLES + 2;
  endproperty
  a_short: assert property (p_short) else $error("short length wrong");
endmodule // zqc_asserts

`default_nettype wire

// ### test/zqc_test.sv
`default_nettype none

module zqc_test;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened budgets keep the run brief
  localparam int INIT = 32;
  localparam int OPER = 16;
  localparam int SHRT = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reqLong = 1'b0;
  logic reqShort = 1'b0;
  logic selfRefreshReq = 1'b0;
  logic banksOpen = 1'b0;
  logic userActivity = 1'b0;
  logic resistorBusy = 1'b0;
  logic cmpHigh = 1'b0;
  logic [5:0] pullUpCode;
  logic [5:0] pullDownCode;
  logic calCurrentOn;
  logic calDone;
  logic resistorClaim;
  logic grant;
  logic calWindow;
  int nFail = 0;
  int testsRun = 0;

  always #5 clk = ~clk;
  zqc_if link ();
  zqc_device #(.INIT_CYCLES(INIT), .OPER_CYCLES(OPER), .SHORT_CYCLES(SHRT)) i_zqc_device (
    .clk(clk), .nrst(nrst), .link(link.device), .cmpHigh(cmpHigh),
    .pullUpCode(pullUpCode), .pullDownCode(pullDownCode),
    .calCurrentOn(calCurrentOn), .calDone(calDone));
  zqc_controller #(.INIT_CYCLES(INIT), .OPER_CYCLES(OPER), .SHORT_CYCLES(SHRT)) i_zqc_controller (
    .clk(clk), .nrst(nrst), .link(link.controller), .reqLong(reqLong),
    .reqShort(reqShort), .selfRefreshReq(selfRefreshReq), .banksOpen(banksOpen),
    .userActivity(userActivity), .resistorBusy(resistorBusy),
    .resistorClaim(resistorClaim), .grant(grant), .calWindow(calWindow));
  zqc_asserts #(.INIT_CYCLES(INIT), .OPER_CYCLES(OPER), .SHORT_CYCLES(SHRT)) i_zqc_asserts (
    .clk(clk), .nrst(nrst), .cmd(link.cmd), .cmdValid(link.cmdValid),
    .otherActivity(link.otherActivity), .allPrecharged(link.allPrecharged),
    .selfRefresh(link.selfRefresh), .busy(link.busy));

  // ==========================================================
  // reporting
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // one calibration, timed from grant to done
  task automatic cal(input string name, input logic lng, input int bud, input logic req);
    int c;
    logic [5:0] up0;
    logic early;
    logic on;
    logic claim;
    c = 0;
    early = 1'b0;
    on = 1'b0;
    claim = 1'b0;
    up0 = pullUpCode;
    // the forced first long needs no request, its grant already stands
    if (req) begin
      @(posedge clk);
      reqLong <= lng;
      reqShort <= !lng;
    end
    while (grant !== 1'b1 && c < 300) begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
    reqLong <= 1'b0;
    reqShort <= 1'b0;
    c = c >= 300 ? 300 : 0;
    while (calDone !== 1'b1 && c < 300) begin
      @(negedge clk);
      c++;
      on |= calCurrentOn === 1'b1;
      claim |= resistorClaim === 1'b1;
      if (calDone !== 1'b1 && pullUpCode !== up0) early = 1'b1;
    end
    if (c >= 300) begin
      nFail++;
      final_report();
    end
    check({name, " length"}, 32'(c >= bud && c <= bud + 5), 32'h1);
    check({name, " current on"}, 32'(on), 32'h1);
    check({name, " early codes"}, 32'(early), 32'h0);
    check({name, " claim"}, 32'(claim), 32'h1);
    check({name, " current off"}, 32'(calCurrentOn), 32'h0);
    $display("test %s done", name);
  endtask

  // request held while something blocks it; reports any grant
  task automatic blocked(output logic g);
    g = 1'b0;
    @(posedge clk);
    reqShort <= 1'b1;
    repeat (40) begin
      @(negedge clk);
      g |= grant === 1'b1;
    end
    @(posedge clk);
    reqShort <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    logic g;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    cmpHigh <= 1'b1;
    @(negedge clk);
    check("up code", 32'(pullUpCode), 32'h20);
    check("down code", 32'(pullDownCode), 32'h20);
    check("busy", 32'(link.busy), 32'h0);
    check("forced long grant", 32'(grant), 32'h1);
    $display("test reset done");
    cal("first long", 1'b1, INIT, 1'b0);
    check("up moved", 32'(pullUpCode !== 6'h20), 32'h1);
    @(posedge clk);
    userActivity <= 1'b1;
    cal("later long", 1'b1, OPER, 1'b1);
    cal("short", 1'b0, SHRT, 1'b1);
    cal("short again", 1'b0, SHRT, 1'b1);
    @(posedge clk);
    userActivity <= 1'b0;
    // self refresh exit must not start anything
    selfRefreshReq <= 1'b1;
    repeat (20) @(posedge clk);
    selfRefreshReq <= 1'b0;
    g = 1'b0;
    repeat (30) begin
      @(negedge clk);
      g |= link.busy === 1'b1;
    end
    check("self refresh busy", 32'(g), 32'h0);
    $display("test self refresh done");
    @(posedge clk);
    resistorBusy <= 1'b1;
    blocked(g);
    check("resistor grant", 32'(g), 32'h0);
    $display("test resistor blocked done");
    resistorBusy <= 1'b0;
    cal("resistor freed", 1'b0, SHRT, 1'b1);
    @(posedge clk);
    banksOpen <= 1'b1;
    blocked(g);
    check("open banks grant", 32'(g), 32'h0);
    $display("test open banks done");
    banksOpen <= 1'b0;
    cal("banks closed", 1'b0, SHRT, 1'b1);
    final_report();
  end
endmodule // zqc_test

`default_nettype wire
